//--- pkg/cie_consts.vh
// Purpose: shared constants of the core execution block
// Assumes: included by the alu, the core, the checker and the bench
// Notes:   one definition per number; the alu and the core use these names
`ifndef CIE_CONSTS_VH
`define CIE_CONSTS_VH

`define CIE_PC_W          10
`define CIE_CLK_MHZ       200

// i/o space, 6-bit addresses
`define CIE_IO_STATUS     6'h3F
`define CIE_IO_SP_LOW     6'h3D
`define CIE_IO_FLAGS      6'h08
`define CIE_IO_PORT       6'h09
`define CIE_IO_PINS       6'h0A
`define CIE_IO_BITOP_MAX  6'h1F

`define CIE_STATUS_RST    8'h00
`define CIE_SP_RST        8'h00
`define CIE_PORT_RST      8'h00
`define CIE_FLAGS_RST     8'h00
`define CIE_FULL_MASK     8'hFF

// status bit positions
`define CIE_F_C           0
`define CIE_F_Z           1
`define CIE_F_N           2
`define CIE_F_V           3
`define CIE_F_S           4
`define CIE_F_H           5
`define CIE_F_T           6
`define CIE_F_I           7

// alu operations
`define CIE_ALU_ADD       3'h0
`define CIE_ALU_ADC       3'h1
`define CIE_ALU_SUB       3'h2
`define CIE_ALU_SBC       3'h3
`define CIE_ALU_AND       3'h4
`define CIE_ALU_OR        3'h5
`define CIE_ALU_EOR       3'h6
`define CIE_ALU_PASS      3'h7

// sequencer states, one-hot
`define CIE_ST_EXEC       7'h01
`define CIE_ST_WAIT       7'h02
`define CIE_ST_SKIP       7'h04
`define CIE_ST_SKIP2      7'h08
`define CIE_ST_CALL2      7'h10
`define CIE_ST_RET2       7'h20
`define CIE_ST_RET3       7'h40

`endif

//--- design/cie_alu.v
// Purpose: 8-bit arithmetic and logic unit with status update
// Assumes: purely combinational; the core decides what to keep
// Notes:   logic ops leave half-carry and carry untouched
`include "cie_consts.vh"

module cie_alu (
    input  wire [2:0] op_in,
    input  wire [7:0] a_in,
    input  wire [7:0] b_in,
    input  wire [7:0] core_status_flags_in,
    output reg  [7:0] result_out,
    output reg  [7:0] core_status_flags_out
);
    reg [8:0] sum;
    reg       cin;
    reg       is_arith;
    reg       is_sub;
    reg [7:0] r;

    always @*
    begin
        cin      = core_status_flags_in[`CIE_F_C];
        is_arith = (op_in[2] == 1'b0);
        is_sub   = op_in[1];
        sum      = 9'h000;
        case (op_in)
            `CIE_ALU_ADD: sum = {1'b0, a_in} + {1'b0, b_in};
            `CIE_ALU_ADC: sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin};
            `CIE_ALU_SUB: sum = {1'b0, a_in} - {1'b0, b_in};
            `CIE_ALU_SBC: sum = {1'b0, a_in} - {1'b0, b_in} - {8'h00, cin};
            `CIE_ALU_AND: sum = {1'b0, a_in & b_in};
            `CIE_ALU_OR:  sum = {1'b0, a_in | b_in};
            `CIE_ALU_EOR: sum = {1'b0, a_in ^ b_in};
            default:      sum = {1'b0, b_in};
        endcase
        r          = sum[7:0];
        result_out = r;
        core_status_flags_out   = core_status_flags_in;
        if (is_arith && !is_sub)
        begin
            core_status_flags_out[`CIE_F_H] = (a_in[3] & b_in[3]) | (b_in[3] & ~r[3]) | (~r[3] & a_in[3]);
            core_status_flags_out[`CIE_F_V] = (a_in[7] & b_in[7] & ~r[7]) | (~a_in[7] & ~b_in[7] & r[7]);
            core_status_flags_out[`CIE_F_C] = (a_in[7] & b_in[7]) | (b_in[7] & ~r[7]) | (~r[7] & a_in[7]);
        end
        else if (is_arith)
        begin
            core_status_flags_out[`CIE_F_H] = (~a_in[3] & b_in[3]) | (b_in[3] & r[3]) | (r[3] & ~a_in[3]);
            core_status_flags_out[`CIE_F_V] = (a_in[7] & ~b_in[7] & ~r[7]) | (~a_in[7] & b_in[7] & r[7]);
            core_status_flags_out[`CIE_F_C] = (~a_in[7] & b_in[7]) | (b_in[7] & r[7]) | (r[7] & ~a_in[7]);
        end
        else
        begin
            core_status_flags_out[`CIE_F_V] = 1'b0;
        end
        core_status_flags_out[`CIE_F_N] = r[7];
        // borrow chains keep zero only if every byte so far was zero
        if (op_in == `CIE_ALU_SBC)
            core_status_flags_out[`CIE_F_Z] = (r == 8'h00) & core_status_flags_in[`CIE_F_Z];
        else
            core_status_flags_out[`CIE_F_Z] = (r == 8'h00);
        core_status_flags_out[`CIE_F_S] = r[7] ^ core_status_flags_out[`CIE_F_V];
    end
endmodule // cie_alu

//--- design/cie_core.v
// Purpose: instruction execution of an 8-bit core: alu, flow, skips, i/o bit ops
// Assumes: program memory answers pmem_data_in in the same cycle as pmem_addr_out
// Notes:   no pipeline; each instruction takes exactly its cycle count
`include "cie_consts.vh"

// Functional notes
// - register add, with carry, one clock, flags
// - word add/subtract immediate, two clocks, flags
// - subtract register/constant, with borrow, one clock
// - and, or, xor update zero, negative, overflow
// - set-bits ors constant mask, one clock
// - clear-bits ands with complemented mask
// - test ands register with itself, unchanged
// - pointer jump loads pc, two clocks
// - pointer call saves return, three clocks
// - compare-skip-equal skips one or two words
// - compares set flags, destination kept
// - register bit skips on clear or set
// - i/o bit skips on clear or set
// - flag branch adds k+1, one/two clocks
// - signed branches use negative xor overflow
// - unsigned branches test carry only
// - half-carry, transfer, overflow branches by flag
// - interrupt branches test global enable flag
// - some i/o flags clear on writing one
// - bit set/clear rewrites whole i/o register
// - bit set/clear reach addresses 00-1F only
module cie_core (
    input  wire                   clk_in,
    input  wire                   rst_in,
    input  wire [15:0]            pmem_data_in,
    input  wire [7:0]             io_event_in,
    input  wire [7:0]             io_pins_in,
    output wire [`CIE_PC_W-1:0]   pmem_addr_out,
    output wire [7:0]             status_out,
    output wire [7:0]             sp_low_out,
    output wire [7:0]             io_port_out,
    output wire [7:0]             io_flags_out
);
    reg  [`CIE_PC_W-1:0] pc;
    reg  [7:0]           core_status_flags;
    reg  [7:0]           sp;
    reg  [6:0]           state;
    reg  [7:0]           ret_hi;
    reg  [7:0]           io_port;
    reg  [7:0]           io_flags;
    reg  [7:0]           ev_s1;
    reg  [7:0]           ev_s2;
    reg  [7:0]           pin_s1;
    reg  [7:0]           pin_s2;
    reg  [7:0]           rf [0:31];
    reg  [7:0]           sram [0:127];

    reg  [`CIE_PC_W-1:0] next_pc;
    reg  [7:0]           next_core_status_flags;
    reg  [7:0]           next_sp;
    reg  [6:0]           next_state;
    reg  [7:0]           next_ret;
    reg  [7:0]           next_port;
    reg                  rf_we;
    reg                  rf_we2;
    reg  [4:0]           rf_wa;
    reg  [7:0]           rf_wd;
    reg  [7:0]           rf_wd2;
    reg                  mem_we;
    reg  [7:0]           mem_wd;
    reg                  flag_we;
    reg  [7:0]           flag_wd;
    reg  [2:0]           alu_op;
    reg                  use_imm;
    reg  [4:0]           ra_sel;
    reg  [4:0]           rb_sel;
    reg  [7:0]           io_rd;
    reg  [7:0]           io_wd;
    reg  [15:0]          word_res;
    reg                  skip_hit;

    wire [15:0]          instr   = pmem_data_in;
    wire [4:0]           d_full  = instr[8:4];
    wire [4:0]           d_imm   = {1'b1, instr[7:4]};
    wire [4:0]           r_full  = {instr[9], instr[3:0]};
    wire [7:0]           k8      = {instr[11:8], instr[3:0]};
    wire [15:0]          k6      = {10'h000, instr[7:6], instr[3:0]};
    wire [4:0]           w_lo    = {2'b11, instr[5:4], 1'b0};
    wire [5:0]           io_a6   = {instr[10:9], instr[3:0]};
    wire [5:0]           io_a5   = {1'b0, instr[7:3]};
    wire [5:0]           io_ra   = (instr[15:12] == 4'hB) ? io_a6 : io_a5;
    wire [`CIE_PC_W-1:0] pc_inc  = pc + 10'h001;
    wire [`CIE_PC_W-1:0] br_tgt  = pc_inc + {{3{instr[9]}}, instr[9:3]};
    wire [`CIE_PC_W-1:0] rel_tgt = pc_inc + instr[9:0];
    wire [7:0]           ra      = rf[ra_sel];
    wire [7:0]           rb      = rf[rb_sel];
    wire [7:0]           mem_rd  = sram[sp[6:0]];
    wire [15:0]          wval    = {rb, ra};
    wire                 is_rr   = (instr[15:14] == 2'b00) && (instr[13:12] != 2'b11)
                                   && (instr[13:10] != 4'h0);
    wire                 is_imm  = (instr[15:14] == 2'b01) || (instr[15:12] == 4'h3)
                                   || (instr[15:12] == 4'hE);
    wire                 two_word = ((instr[15:10] == 6'h24) && (instr[3:0] == 4'h0))
                                   || ((instr[15:9] == 7'h4A) && (instr[3:2] == 2'b11));
    wire [7:0]           alu_res;
    wire [7:0]           alu_core_status_flags;

    cie_alu u_alu (
        .op_in      (alu_op),
        .a_in       (ra),
        .b_in       (use_imm ? k8 : rb),
        .core_status_flags_in    (core_status_flags),
        .result_out (alu_res),
        .core_status_flags_out   (alu_core_status_flags)
    );

    assign pmem_addr_out = pc;
    assign status_out    = core_status_flags;
    assign sp_low_out    = sp;
    assign io_port_out   = io_port;
    assign io_flags_out  = io_flags;

    // register read ports: word ops and the pointer read a pair
    always @*
    begin
        ra_sel = is_imm ? d_imm : d_full;
        rb_sel = r_full;
        if (instr[15:9] == 7'h4B)
        begin
            ra_sel = w_lo;
            rb_sel = w_lo + 5'h01;
        end
        else if ((instr[15:9] == 7'h4A) && (instr[3:0] == 4'h9))
        begin
            ra_sel = 5'h1E;
            rb_sel = 5'h1F;
        end
    end

    // i/o read view; unmapped and reserved addresses read zero
    always @*
    begin
        case (io_ra)
            `CIE_IO_STATUS: io_rd = core_status_flags;
            `CIE_IO_SP_LOW: io_rd = sp;
            `CIE_IO_FLAGS:  io_rd = io_flags;
            `CIE_IO_PORT:   io_rd = io_port;
            `CIE_IO_PINS:   io_rd = pin_s2;
            default:        io_rd = 8'h00;
        endcase
    end

    always @*
    begin
        next_pc    = pc;
        next_core_status_flags  = core_status_flags;
        next_sp    = sp;
        next_state = state;
        next_ret   = ret_hi;
        next_port  = io_port;
        rf_we      = 1'b0;
        rf_we2     = 1'b0;
        rf_wa      = ra_sel;
        rf_wd      = alu_res;
        rf_wd2     = 8'h00;
        mem_we     = 1'b0;
        mem_wd     = 8'h00;
        flag_we    = 1'b0;
        flag_wd    = 8'h00;
        alu_op     = `CIE_ALU_PASS;
        use_imm    = is_imm;
        io_wd      = io_rd;
        word_res   = 16'h0000;
        skip_hit   = 1'b0;
        case (state)
            `CIE_ST_EXEC:
            begin
                next_pc = pc_inc;
                if (is_rr)
                begin
                    case (instr[13:10])
                        4'h1: alu_op = `CIE_ALU_SBC;
                        4'h2: alu_op = `CIE_ALU_SBC;
                        4'h3: alu_op = `CIE_ALU_ADD;
                        4'h5: alu_op = `CIE_ALU_SUB;
                        4'h6: alu_op = `CIE_ALU_SUB;
                        4'h7: alu_op = `CIE_ALU_ADC;
                        4'h8: alu_op = `CIE_ALU_AND;
                        4'h9: alu_op = `CIE_ALU_EOR;
                        4'hA: alu_op = `CIE_ALU_OR;
                        default: alu_op = `CIE_ALU_PASS;
                    endcase
                    if (instr[13:10] == 4'h4)
                        skip_hit = (ra == rb);
                    else if (instr[13:10] == 4'hB)
                        rf_we = 1'b1;
                    else
                    begin
                        next_core_status_flags = alu_core_status_flags;
                        rf_we     = (instr[13:10] != 4'h1) && (instr[13:10] != 4'h5);
                    end
                end
                else if (is_imm)
                begin
                    case (instr[15:12])
                        4'h3: alu_op = `CIE_ALU_SUB;
                        4'h4: alu_op = `CIE_ALU_SBC;
                        4'h5: alu_op = `CIE_ALU_SUB;
                        4'h6: alu_op = `CIE_ALU_OR;
                        // clear-bits arrives here with its mask already taken from full ones
                        4'h7: alu_op = `CIE_ALU_AND;
                        default: alu_op = `CIE_ALU_PASS;
                    endcase
                    rf_we = (instr[15:12] != 4'h3);
                    if (instr[15:12] != 4'hE)
                        next_core_status_flags = alu_core_status_flags;
                end
                else if (instr[15:9] == 7'h4B)
                begin
                    // both bytes written at once; the second clock is an idle slot
                    if (instr[8])
                        word_res = wval - k6;
                    else
                        word_res = wval + k6;
                    rf_we  = 1'b1;
                    rf_wa  = ra_sel;
                    rf_wd  = word_res[7:0];
                    rf_we2 = 1'b1;
                    rf_wd2 = word_res[15:8];
                    next_core_status_flags[`CIE_F_N] = word_res[15];
                    next_core_status_flags[`CIE_F_Z] = (word_res == 16'h0000);
                    if (instr[8])
                    begin
                        next_core_status_flags[`CIE_F_V] = wval[15] & ~word_res[15];
                        next_core_status_flags[`CIE_F_C] = word_res[15] & ~wval[15];
                    end
                    else
                    begin
                        next_core_status_flags[`CIE_F_V] = ~wval[15] & word_res[15];
                        next_core_status_flags[`CIE_F_C] = ~word_res[15] & wval[15];
                    end
                    next_core_status_flags[`CIE_F_S] = next_core_status_flags[`CIE_F_N] ^ next_core_status_flags[`CIE_F_V];
                    next_state = `CIE_ST_WAIT;
                end
                else if ((instr[15:9] == 7'h4A) && (instr[3:0] == 4'h9))
                begin
                    next_pc = wval[`CIE_PC_W-1:0];
                    if (instr[4])
                    begin
                        mem_we     = 1'b1;
                        mem_wd     = pc_inc[7:0];
                        next_ret   = {6'h00, pc_inc[9:8]};
                        next_sp    = sp - 8'h01;
                        next_state = `CIE_ST_CALL2;
                    end
                    else
                        next_state = `CIE_ST_WAIT;
                end
                else if ((instr[15:5] == 11'h4A8) && (instr[3:0] == 4'h8))
                begin
                    next_sp    = sp + 8'h01;
                    next_state = `CIE_ST_RET2;
                    if (instr[4])
                        next_core_status_flags[`CIE_F_I] = 1'b1;
                end
                else if (instr[15:13] == 3'h6)
                begin
                    next_pc = rel_tgt;
                    if (instr[12])
                    begin
                        mem_we     = 1'b1;
                        mem_wd     = pc_inc[7:0];
                        next_ret   = {6'h00, pc_inc[9:8]};
                        next_sp    = sp - 8'h01;
                        next_state = `CIE_ST_CALL2;
                    end
                    else
                        next_state = `CIE_ST_WAIT;
                end
                else if ((instr[15:10] == 6'h26) && !instr[8])
                begin
                    // only five address bits exist, so the reach stops at 1F
                    io_wd          = io_rd;
                    io_wd[instr[2:0]] = instr[9];
                end
                else if ((instr[15:10] == 6'h26) && instr[8])
                    skip_hit = (io_rd[instr[2:0]] == instr[9]);
                else if (instr[15:12] == 4'hB)
                begin
                    if (instr[11])
                        io_wd = ra;
                    else
                    begin
                        rf_we = 1'b1;
                        rf_wd = io_rd;
                    end
                end
                else if (instr[15:11] == 5'h1E)
                begin
                    // generic flag test covers the signed, unsigned and flag-named forms
                    if (core_status_flags[instr[2:0]] == ~instr[10])
                    begin
                        next_pc    = br_tgt;
                        next_state = `CIE_ST_WAIT;
                    end
                end
                else if ((instr[15:11] == 5'h1F) && !instr[3])
                    skip_hit = (ra[instr[2:0]] == instr[9]);
                if (skip_hit)
                    next_state = `CIE_ST_SKIP;
            end
            `CIE_ST_SKIP:
            begin
                next_pc    = pc_inc;
                next_state = two_word ? `CIE_ST_SKIP2 : `CIE_ST_EXEC;
            end
            `CIE_ST_SKIP2:
            begin
                next_pc    = pc_inc;
                next_state = `CIE_ST_EXEC;
            end
            `CIE_ST_CALL2:
            begin
                mem_we     = 1'b1;
                mem_wd     = ret_hi;
                next_sp    = sp - 8'h01;
                next_state = `CIE_ST_WAIT;
            end
            `CIE_ST_RET2:
            begin
                next_ret   = mem_rd;
                next_sp    = sp + 8'h01;
                next_state = `CIE_ST_RET3;
            end
            `CIE_ST_RET3:
            begin
                next_pc    = {ret_hi[1:0], mem_rd};
                next_state = `CIE_ST_WAIT;
            end
            `CIE_ST_WAIT:
                next_state = `CIE_ST_EXEC;
            default:
                next_state = `CIE_ST_EXEC;
        endcase
        // i/o writes from out and from the bit set/clear path
        if ((state == `CIE_ST_EXEC) && ((instr[15:11] == 5'h17)
            || ((instr[15:10] == 6'h26) && !instr[8])))
        begin
            case (io_ra)
                `CIE_IO_STATUS: next_core_status_flags = io_wd;
                `CIE_IO_SP_LOW: next_sp   = io_wd;
                `CIE_IO_PORT:   next_port = io_wd;
                `CIE_IO_FLAGS:
                begin
                    flag_we = 1'b1;
                    flag_wd = io_wd;
                end
                default:        next_port = io_port;
            endcase
        end
    end

    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pc      <= {`CIE_PC_W{1'b0}};
            core_status_flags    <= `CIE_STATUS_RST;
            sp      <= `CIE_SP_RST;
            state   <= `CIE_ST_EXEC;
            ret_hi  <= 8'h00;
            io_port <= `CIE_PORT_RST;
            ev_s1   <= 8'h00;
            ev_s2   <= 8'h00;
            pin_s1  <= 8'h00;
            pin_s2  <= 8'h00;
        end
        else
        begin
            pc      <= next_pc;
            core_status_flags    <= next_core_status_flags;
            sp      <= next_sp;
            state   <= next_state;
            ret_hi  <= next_ret;
            io_port <= next_port;
            ev_s1   <= io_event_in;
            ev_s2   <= ev_s1;
            pin_s1  <= io_pins_in;
            pin_s2  <= pin_s1;
        end
    end

    // write-one-to-clear flags; an event in the clearing cycle still sets
    localparam [7:0] FLAGS_RST = `CIE_FLAGS_RST;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_flag
            always @(posedge clk_in or posedge rst_in)
            begin
                if (rst_in)
                    io_flags[gi] <= FLAGS_RST[gi];
                else if (ev_s2[gi])
                    io_flags[gi] <= 1'b1;
                else if (flag_we && flag_wd[gi])
                    io_flags[gi] <= 1'b0;
            end
        end
    endgenerate

    // data storage is not reset; software initialises it
    always @(posedge clk_in)
    begin
        if (rf_we)
            rf[rf_wa] <= rf_wd;
        if (rf_we2)
            rf[rf_wa + 5'h01] <= rf_wd2;
        if (mem_we)
            sram[sp[6:0]] <= mem_wd;
    end
endmodule // cie_core

//--- testbench/cie_core_checker.sv
// Purpose: assertions on the pins of the core execution block
// Assumes: one clock, asynchronous active-high reset
// Notes:   an execute cycle is inferred after a load immediate, which never stalls
`include "cie_consts.vh"
module cie_core_checker (
    input wire logic                 clk_in,
    input wire logic                 rst_in,
    input wire logic [15:0]          pmem_data_in,
    input wire logic [7:0]           io_event_in,
    input wire logic [`CIE_PC_W-1:0] pmem_addr_out,
    input wire logic [7:0]           status_out,
    input wire logic [7:0]           sp_low_out,
    input wire logic [7:0]           io_flags_out
);
    logic [15:0]          pw;
    logic [`CIE_PC_W-1:0] pp;
    wire                  ex    = (pw[15:12] == 4'hE) && (pmem_addr_out == pp + 1'b1);
    wire [`CIE_PC_W-1:0]  tgt_j = pp + 1'b1 + pw[9:0];
    wire [`CIE_PC_W-1:0]  tgt_b = pp + 1'b1 + {{3{pw[9]}}, pw[9:3]};
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pw <= 16'h0000;
            pp <= '0;
        end
        else
        begin
            pw <= pmem_data_in;
            pp <= pmem_addr_out;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_exec; ex; endsequence
    sequence s_hold; $stable(pmem_addr_out); endsequence
    a_reset_vals: assert property ($past(rst_in) |-> pmem_addr_out == '0 && status_out == 8'h00
        && sp_low_out == 8'h00) else $error("reset values wrong");
    a_add_one_clk: assert property (s_exec ##0 pmem_data_in[15:10] == 6'h03 |=>
        pmem_addr_out == pp + 1'b1 && $stable(status_out[7:6])) else $error("add timing wrong");
    a_logic_flags: assert property (s_exec ##0 pmem_data_in[15:13] == 3'h3 |=> !status_out[3]
        && status_out[4] == status_out[2] && $stable(status_out[0]) && $stable(status_out[5]))
        else $error("logic flags wrong");
    a_rjmp_two_clk: assert property (s_exec ##0 pmem_data_in[15:12] == 4'hC |=>
        pmem_addr_out == tgt_j ##1 s_hold) else $error("jump wrong");
    a_rcall_three_clk: assert property (s_exec ##0 pmem_data_in[15:12] == 4'hD |=> pmem_addr_out == tgt_j
        ##1 ($stable(pmem_addr_out) && sp_low_out == $past(sp_low_out, 2) - 8'h02) ##1 s_hold)
        else $error("call wrong");
    a_branch_taken: assert property (s_exec ##0 (pmem_data_in[15:11] == 5'h1E
        && status_out[pmem_data_in[2:0]] != pmem_data_in[10]) |=> pmem_addr_out == tgt_b ##1 s_hold)
        else $error("taken branch wrong");
    a_branch_not_taken: assert property (s_exec ##0 (pmem_data_in[15:11] == 5'h1E
        && status_out[pmem_data_in[2:0]] == pmem_data_in[10]) |=> pmem_addr_out == pp + 1'b1)
        else $error("branch fell through wrong");
    a_event_sets_flag: assert property (io_event_in[0] [*4] |-> io_flags_out[0])
        else $error("event flag not set");
endmodule // cie_core_checker

//--- testbench/tb.sv
// Purpose: self-checking bench for the core execution block
// Assumes: a small rom answers the pc in the same cycle
// Notes:   results show through the port register, status, stack pointer and flags
`include "cie_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_in      = 1'b0;
    logic                 rst_in      = 1'b1;
    logic [7:0]           io_event_in = 8'h00;
    logic [7:0]           io_pins_in  = 8'hA5;
    logic [15:0]          rom [0:31];
    wire  [15:0]          pmem_data_in;
    wire  [`CIE_PC_W-1:0] pmem_addr_out;
    wire  [7:0]           status_out, sp_low_out, io_port_out, io_flags_out;
    int                   n_mismatch  = 0;
    int                   num_checks  = 0;
    assign pmem_data_in = rom[pmem_addr_out[4:0]];
    cie_core dut (.clk_in(clk_in), .rst_in(rst_in), .pmem_data_in(pmem_data_in), .io_event_in(io_event_in),
        .io_pins_in(io_pins_in), .pmem_addr_out(pmem_addr_out), .status_out(status_out),
        .sp_low_out(sp_low_out), .io_port_out(io_port_out), .io_flags_out(io_flags_out));
    initial
    begin
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // rom is reloaded under reset so no half-loaded program ever runs
    task automatic prog(input logic [15:0] q[$], input int n);
        @(posedge clk_in);
        rst_in <= 1'b1;
        foreach (rom[i]) rom[i] <= (i < q.size()) ? q[i] : 16'hCFFF;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic t_add;
        prog({16'hE70F, 16'hE011, 16'h0F01, 16'hB909}, 8);
        chk(io_port_out, 8'h80);
        chk(status_out, 8'h2C);
    endtask
    task automatic t_logic;
        prog({16'hE000, 16'h5001, 16'hE020, 16'h700F, 16'hE020, 16'h6800, 16'hB909}, 12);
        chk(io_port_out, 8'h8F);
        chk(status_out, 8'h35);
    endtask
    task automatic t_branch;
        prog({16'hE000, 16'h5001, 16'hE020, 16'hF408, 16'hE111, 16'hF008, 16'hE515, 16'hF00C,
              16'hE616, 16'hB919}, 16);
        chk(io_port_out, 8'h11);
    endtask
    task automatic t_call;
        prog({16'hE600, 16'hBF0D, 16'hE717, 16'hD002, 16'hB919, 16'hCFFF, 16'hE000, 16'hC000,
              16'h9518}, 20);
        chk(io_port_out, 8'h77);
        chk(status_out, 8'h80);
        chk(sp_low_out, 8'h60);
    endtask
    // pins need two edges of sync, so the i/o skips come after the loads
    task automatic t_skip;
        prog({16'hE011, 16'hEF8F, 16'hE79F, 16'h9B50, 16'hE012, 16'h9951, 16'hE013, 16'h9601,
              16'h1311, 16'h9000, 16'hE014, 16'hBF9D, 16'hB919}, 20);
        chk(io_port_out, 8'h01);
        chk(sp_low_out, 8'h80);
        chk(status_out, 8'h0C);
    endtask
    // a bit set on another bit wipes pending flags; an event still high keeps its flag
    task automatic t_flags;
        fork
            prog({16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                  16'h0000, 16'hB10A, 16'hB909, 16'h9A47}, 16);
            begin
                repeat (3) @(posedge clk_in);
                io_event_in <= 8'h0F;
                repeat (6) @(posedge clk_in);
                io_event_in <= 8'h08;
                repeat (3) @(posedge clk_in);
                #1;
                chk(io_flags_out, 8'h0F);
            end
        join
        chk(io_flags_out, 8'h08);
        chk(io_port_out, 8'hA5);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        foreach (rom[i]) rom[i] = 16'hCFFF;
        repeat (20) @(posedge clk_in);
        #1;
        chk(status_out, 8'h00);
        chk(sp_low_out, 8'h00);
        t_add;
        t_logic;
        t_branch;
        t_call;
        t_skip;
        t_flags;
        end_of_test;
    end
    // the tests need well under a thousand cycles
    initial
    begin
        #5000;
        n_mismatch++;
        end_of_test;
    end
endmodule // tb
bind cie_core cie_core_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .pmem_data_in(pmem_data_in),
    .io_event_in(io_event_in), .pmem_addr_out(pmem_addr_out), .status_out(status_out),
    .sp_low_out(sp_low_out), .io_flags_out(io_flags_out));
